// ===== src/vic_pkg.sv
// Constants, field layout and vector table of the vectored interrupt control.
// Assumes an APB master with 32-bit data and a core acknowledge interface.
// Notes on behaviour
// - Simultaneous requests served in fixed order, 1 highest to 7 lowest.
// - Any-edge external irq shares order 1 and vector 0002H with timer.
// - Selectable-edge externals take orders 2, 3 and vectors 0004H, 0006H.
// - Serial transfer end: internal, order 4, vector 0008H.
// - Event counter match: internal, order 5, vector 000AH.
// - Pulse generator match: internal, order 6, vector 000CH.
// - Key scan timing: internal, lowest order 7, vector 000EH.
// - Test sources are enable-gated but never raise a vectored interrupt.
// - Third external input rising edges set a testable flag; watch timer is test.
// - Acknowledge is gated by per-source enable and the master enable.
// - Service start address comes from the vector table entry.
// - The priority-selected source may nest into a running service.
// - Software can read every request flag to poll events.
// - Any enabled pending request releases standby.
// - All flags and settings are reachable as addressed registers.
// - Flag sets on source request and clears when its service begins.
// - Vectored request when flag and enable both set; software set counts.
// - Priority select bits 2:0 pick nesting source; bit 3 master enable.
// - Reset clears all request and enable flags.
package vic_pkg;

  localparam int NUM_SRC = 10;
  localparam int ADDR_W = 8;
  localparam int VEC_W = 3;
  localparam int VADDR_W = 16;

  // Source indices; vectored sources 2..7 equal their vector number
  localparam int SRC_BT = 0;
  localparam int SRC_ANY = 1;
  localparam int SRC_A = 2;
  localparam int SRC_B = 3;
  localparam int SRC_SER = 4;
  localparam int SRC_EVT = 5;
  localparam int SRC_PG = 6;
  localparam int SRC_KS = 7;
  localparam int SRC_T2 = 8;
  localparam int SRC_WT = 9;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_REQ = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ENA = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PRIO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EDGE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;

  // Priority select fields
  localparam int PS_W = 4;
  localparam int PS_ME_BIT = 3;

  // Edge select fields: one bit per selectable input, 1 = falling
  localparam int EDGE_W = 2;
  localparam int EDGE_A_BIT = 0;
  localparam int EDGE_B_BIT = 1;

  // Status fields
  localparam int ST_VEC_LSB = 0;
  localparam int ST_INS_LSB = 4;
  localparam int ST_WAKE_BIT = 11;
  localparam int ST_SHARED_BIT = 12;

  // Reset values
  localparam logic [NUM_SRC-1:0] RST_FLAGS = 10'h000;
  localparam logic [PS_W-1:0] RST_PS = 4'h0;
  localparam logic [EDGE_W-1:0] RST_EDGE = 2'h0;
  localparam logic [VEC_W-1:0] VEC_NONE = 3'h0;
  localparam logic [VEC_W-1:0] VEC_SHARED = 3'h1;

  // Vector table entries
  localparam logic [VADDR_W-1:0] VA_1 = 16'h0002;
  localparam logic [VADDR_W-1:0] VA_2 = 16'h0004;
  localparam logic [VADDR_W-1:0] VA_3 = 16'h0006;
  localparam logic [VADDR_W-1:0] VA_4 = 16'h0008;
  localparam logic [VADDR_W-1:0] VA_5 = 16'h000A;
  localparam logic [VADDR_W-1:0] VA_6 = 16'h000C;
  localparam logic [VADDR_W-1:0] VA_7 = 16'h000E;

  // Edge detector modes
  typedef enum logic [1:0] {
    VIC_RISE = 2'b00,
    VIC_FALL = 2'b01,
    VIC_BOTH = 2'b10
  } vic_edge_t;

endpackage : vic_pkg

// ===== src/vic_edge_det.sv
// Pin synchroniser and edge detector for one external interrupt input.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps
module vic_edge_det (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic pin,
  input wire vic_pkg::vic_edge_t mode,
  output logic edge_pulse
);

  logic sync1;
  logic sync2;
  logic prev;
  logic next_pulse;

  // Edge decision only looks at the settled second stage
  always_comb
  begin
    case (mode)
      vic_pkg::VIC_RISE: next_pulse = sync2 & ~prev;
      vic_pkg::VIC_FALL: next_pulse = ~sync2 & prev;
      vic_pkg::VIC_BOTH: next_pulse = sync2 ^ prev;
      default: next_pulse = 1'b0;
    endcase
  end

  // Two-stage synchroniser, history and registered pulse
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
      prev <= sync2;
      edge_pulse <= next_pulse;
    end
  end

endmodule : vic_edge_det

// ===== src/vic_ctrl.sv
// Vectored interrupt control: flags, enables, priority, nesting, APB regs.
// Assumes internal event inputs are one-cycle pulses on core_clk and that
// the core acknowledges a request with irq_ack and ends a service with
// irq_return, both one-cycle pulses.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module vic_ctrl (
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic [vic_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal event pulses
  input wire logic interval_timer_irq,
  input wire logic serial_done_irq,
  input wire logic event_counter_match_irq,
  input wire logic pulse_gen_match_irq,
  input wire logic key_scan_timing_irq,
  input wire logic watch_timer_test_source,
  // External pins
  input wire logic any_edge_ext_irq,
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  input wire logic rising_edge_test_input,
  // Core side
  output logic irq_req,
  output logic [vic_pkg::VADDR_W-1:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic standby_wake
);

  // Request flags, enables and settings
  logic [vic_pkg::NUM_SRC-1:0] req_flag;
  logic [vic_pkg::NUM_SRC-1:0] next_req_flag;
  logic [vic_pkg::NUM_SRC-1:0] source_enable_flag;
  logic [vic_pkg::NUM_SRC-1:0] next_source_enable_flag;
  logic [vic_pkg::PS_W-1:0] priority_select;
  logic [vic_pkg::PS_W-1:0] next_priority_select;
  logic [vic_pkg::EDGE_W-1:0] edge_sel;
  logic [vic_pkg::EDGE_W-1:0] next_edge_sel;

  // Service tracking
  logic [7:1] in_service;
  logic [7:1] next_in_service;
  logic [vic_pkg::VEC_W-1:0] cur_vec;
  logic [vic_pkg::VEC_W-1:0] next_cur_vec;
  logic shared_any;
  logic next_shared_any;

  // Bus read data
  logic [31:0] next_prdata;
  logic next_pslverr;

  // Derived signals
  logic master_irq_enable;
  logic [vic_pkg::VEC_W-1:0] nest_sel;
  logic [vic_pkg::NUM_SRC-1:0] armed;
  logic [7:1] vreq;
  logic [7:1] vallow;
  logic [vic_pkg::NUM_SRC-1:0] set_ev;
  logic [vic_pkg::NUM_SRC-1:0] ack_clr;
  logic ack_take;
  logic wr_en;
  logic rd_setup;
  logic any_edge_pulse;
  logic ext_a_pulse;
  logic ext_b_pulse;
  logic test_in_pulse;
  vic_pkg::vic_edge_t mode_a;
  vic_pkg::vic_edge_t mode_b;

  // Highest order pending vector; lower vector number wins
  function automatic logic [vic_pkg::VEC_W-1:0] pick_vec(
    input logic [7:1] pend
  );
    logic [vic_pkg::VEC_W-1:0] v;
    v = vic_pkg::VEC_NONE;
    for (int i = 7; i >= 1; i--)
    begin
      if (pend[i])
        v = i[vic_pkg::VEC_W-1:0];
    end
    return v;
  endfunction : pick_vec

  // One-hot in-service mask for a vector number
  function automatic logic [7:1] vec_mask(
    input logic [vic_pkg::VEC_W-1:0] v
  );
    logic [7:1] m;
    m = '0;
    for (int i = 1; i <= 7; i++)
    begin
      if (v == i[vic_pkg::VEC_W-1:0])
        m[i] = 1'b1;
    end
    return m;
  endfunction : vec_mask

  // Vector table lookup
  function automatic logic [vic_pkg::VADDR_W-1:0] vec_addr(
    input logic [vic_pkg::VEC_W-1:0] v
  );
    logic [vic_pkg::VADDR_W-1:0] a;
    case (v)
      3'h1: a = vic_pkg::VA_1;
      3'h2: a = vic_pkg::VA_2;
      3'h3: a = vic_pkg::VA_3;
      3'h4: a = vic_pkg::VA_4;
      3'h5: a = vic_pkg::VA_5;
      3'h6: a = vic_pkg::VA_6;
      3'h7: a = vic_pkg::VA_7;
      default: a = '0;
    endcase
    return a;
  endfunction : vec_addr

  // External pins: selectable edges for a and b
  assign mode_a = edge_sel[vic_pkg::EDGE_A_BIT] ? vic_pkg::VIC_FALL
                                                : vic_pkg::VIC_RISE;
  assign mode_b = edge_sel[vic_pkg::EDGE_B_BIT] ? vic_pkg::VIC_FALL
                                                : vic_pkg::VIC_RISE;

  vic_edge_det u_any_edge (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(any_edge_ext_irq),
    .mode(vic_pkg::VIC_BOTH),
    .edge_pulse(any_edge_pulse)
  );

  vic_edge_det u_ext_a (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(ext_irq_a),
    .mode(mode_a),
    .edge_pulse(ext_a_pulse)
  );

  vic_edge_det u_ext_b (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(ext_irq_b),
    .mode(mode_b),
    .edge_pulse(ext_b_pulse)
  );

  // Third external input only ever watches rising edges
  vic_edge_det u_test_in (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(rising_edge_test_input),
    .mode(vic_pkg::VIC_RISE),
    .edge_pulse(test_in_pulse)
  );

  // Event set vector, one bit per source
  always_comb
  begin
    set_ev = '0;
    set_ev[vic_pkg::SRC_BT] = interval_timer_irq;
    set_ev[vic_pkg::SRC_ANY] = any_edge_pulse;
    set_ev[vic_pkg::SRC_A] = ext_a_pulse;
    set_ev[vic_pkg::SRC_B] = ext_b_pulse;
    set_ev[vic_pkg::SRC_SER] = serial_done_irq;
    set_ev[vic_pkg::SRC_EVT] = event_counter_match_irq;
    set_ev[vic_pkg::SRC_PG] = pulse_gen_match_irq;
    set_ev[vic_pkg::SRC_KS] = key_scan_timing_irq;
    set_ev[vic_pkg::SRC_T2] = test_in_pulse;
    set_ev[vic_pkg::SRC_WT] = watch_timer_test_source;
  end

  // Vectored requests; test sources are left out on purpose
  assign master_irq_enable = priority_select[vic_pkg::PS_ME_BIT];
  assign nest_sel = priority_select[vic_pkg::VEC_W-1:0];
  assign armed = req_flag & source_enable_flag;
  always_comb
  begin
    vreq[1] = armed[vic_pkg::SRC_BT] | armed[vic_pkg::SRC_ANY];
    vreq[2] = armed[vic_pkg::SRC_A];
    vreq[3] = armed[vic_pkg::SRC_B];
    vreq[4] = armed[vic_pkg::SRC_SER];
    vreq[5] = armed[vic_pkg::SRC_EVT];
    vreq[6] = armed[vic_pkg::SRC_PG];
    vreq[7] = armed[vic_pkg::SRC_KS];
  end

  // Idle core takes anything; a running service only the selected source
  always_comb
  begin
    for (int i = 1; i <= 7; i++)
    begin
      vallow[i] = vreq[i] & master_irq_enable &
        ((in_service == '0) ||
         ((nest_sel == i[vic_pkg::VEC_W-1:0]) && !in_service[i]));
    end
  end

  // Any enabled request, test sources included, wakes from standby
  assign standby_wake = |armed;

  assign ack_take = irq_ack & irq_req;
  assign irq_req = (cur_vec != vic_pkg::VEC_NONE);

  // Which flag an acknowledge clears; timer first on the shared vector
  always_comb
  begin
    ack_clr = '0;
    if (ack_take)
    begin
      if (cur_vec == vic_pkg::VEC_SHARED)
      begin
        if (shared_any)
          ack_clr[vic_pkg::SRC_ANY] = 1'b1;
        else
          ack_clr[vic_pkg::SRC_BT] = 1'b1;
      end
      else
        ack_clr[cur_vec] = 1'b1;
    end
  end

  // APB decode: zero wait states, errors on unmapped offsets
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Flags and settings next values
  always_comb
  begin
    next_req_flag = req_flag;
    next_source_enable_flag = source_enable_flag;
    next_priority_select = priority_select;
    next_edge_sel = edge_sel;
    if (wr_en)
    begin
      case (paddr)
        vic_pkg::OFF_REQ:
          next_req_flag = pwdata[vic_pkg::NUM_SRC-1:0];
        vic_pkg::OFF_ENA:
          next_source_enable_flag = pwdata[vic_pkg::NUM_SRC-1:0];
        vic_pkg::OFF_PRIO:
          next_priority_select = pwdata[vic_pkg::PS_W-1:0];
        vic_pkg::OFF_EDGE:
          next_edge_sel = pwdata[vic_pkg::EDGE_W-1:0];
        default: ;
      endcase
    end
    // Service start clears, a new event in the same cycle still wins
    next_req_flag = (next_req_flag & ~ack_clr) | set_ev;
  end

  // Service tracking next values
  always_comb
  begin
    next_in_service = in_service;
    // Return retires the highest-order routine in service, the lowest vector number
    if (irq_return)
      next_in_service = in_service & ~vec_mask(pick_vec(in_service));
    if (ack_take)
      next_in_service = next_in_service | vec_mask(cur_vec);
    // Offer is withdrawn for one cycle after a take to let flags settle
    if (ack_take)
      next_cur_vec = vic_pkg::VEC_NONE;
    else
      next_cur_vec = pick_vec(vallow);
    next_shared_any = ~armed[vic_pkg::SRC_BT] &
                      armed[vic_pkg::SRC_ANY];
  end

  // Read data captured in the setup phase, valid during access
  always_comb
  begin
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (rd_setup || (psel && !penable))
    begin
      case (paddr)
        vic_pkg::OFF_REQ:
          next_prdata[vic_pkg::NUM_SRC-1:0] = req_flag;
        vic_pkg::OFF_ENA:
          next_prdata[vic_pkg::NUM_SRC-1:0] = source_enable_flag;
        vic_pkg::OFF_PRIO:
          next_prdata[vic_pkg::PS_W-1:0] = priority_select;
        vic_pkg::OFF_EDGE:
          next_prdata[vic_pkg::EDGE_W-1:0] = edge_sel;
        vic_pkg::OFF_STAT:
        begin
          next_prdata[vic_pkg::ST_VEC_LSB +: vic_pkg::VEC_W] = cur_vec;
          next_prdata[vic_pkg::ST_INS_LSB +: 7] = in_service;
          next_prdata[vic_pkg::ST_WAKE_BIT] = standby_wake;
          next_prdata[vic_pkg::ST_SHARED_BIT] = shared_any;
        end
        default:
          next_pslverr = 1'b1;
      endcase
      if (!rd_setup)
        next_prdata = '0;
    end
  end

  // Flag and setting registers; reset leaves every source disabled
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_flag <= vic_pkg::RST_FLAGS;
      source_enable_flag <= vic_pkg::RST_FLAGS;
      priority_select <= vic_pkg::RST_PS;
      edge_sel <= vic_pkg::RST_EDGE;
    end
    else
    begin
      req_flag <= next_req_flag;
      source_enable_flag <= next_source_enable_flag;
      priority_select <= next_priority_select;
      edge_sel <= next_edge_sel;
    end
  end

  // Service registers and vector output
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_service <= '0;
      cur_vec <= vic_pkg::VEC_NONE;
      shared_any <= 1'b0;
      irq_vector <= '0;
    end
    else
    begin
      in_service <= next_in_service;
      cur_vec <= next_cur_vec;
      shared_any <= next_shared_any;
      irq_vector <= vec_addr(next_cur_vec);
    end
  end

  // Bus answer registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : vic_ctrl

// ===== verif/vic_ctrl_monitor.sv
// Port checker for the vectored interrupt control.
// Assumes it is bound into vic_ctrl; enables are shadowed from APB writes.
`timescale 1ns/1ps
module vic_ctrl_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [vic_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic interval_timer_irq,
  input wire logic irq_req,
  input wire logic [vic_pkg::VADDR_W-1:0] irq_vector,
  input wire logic irq_ack,
  input wire logic standby_wake
);
  logic wr_now;
  logic mapped;
  logic [9:0] ena_sh;
  logic me_sh;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Decode of the access phase
  assign wr_now = psel && penable && pwrite;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  // Shadow enables, so gating is judged without seeing inside
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      {ena_sh, me_sh} <= 11'h000;
    else if (wr_now && paddr == 8'h04)
      ena_sh <= pwdata[9:0];
    else if (wr_now && paddr == 8'h08)
      me_sh <= pwdata[3];
  end
  slverr_bad_a: assert property (psel && penable && !mapped |->
    pslverr) else $error("no error on unmapped access");
  slverr_good_a: assert property (psel && penable && mapped |->
    pready && !pslverr) else $error("error on mapped access");
  ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request stayed after acknowledge");
  req_wake_a: assert property (irq_req && !$past(wr_now) |->
    standby_wake) else $error("request without wake");
  vec_table_a: assert property (irq_req |-> irq_vector inside
    {16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C,
    16'h000E}) else $error("vector outside table");
  ena_gate_a: assert property (ena_sh[7:0] == 8'h00 &&
    $past(ena_sh[7:0]) == 8'h00 |-> !irq_req)
    else $error("request with no vectored enable");
  me_gate_a: assert property (!me_sh && !$past(me_sh) |-> !irq_req)
    else $error("request with master enable off");
  flag_set_a: assert property (interval_timer_irq && ena_sh[0] &&
    !wr_now |=> standby_wake) else $error("timer event lost");
  reset_clear_a: assert property ($rose(arst_n) |->
    !standby_wake && !irq_req) else $error("flags alive after reset");
  take_c: cover property (irq_req && irq_ack);
  bad_c: cover property (psel && penable && !mapped);
  wake_c: cover property (standby_wake && !irq_req);
endmodule : vic_ctrl_monitor

// ===== verif/vic_core_model.sv
// Core model: acknowledges an offered vector after a set delay.
// Assumes irq_ack counts only at an edge where irq_req is high.
`timescale 1ns/1ps
module vic_core_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic irq_req,
  input wire logic [vic_pkg::VADDR_W-1:0] irq_vector,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  output logic irq_ack,
  output logic [vic_pkg::VADDR_W-1:0] taken_vec,
  output logic [7:0] taken_cnt
);
  logic [3:0] wait_cnt;
  // One-cycle ack; vector recorded only at the edge that takes it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      {irq_ack, wait_cnt, taken_vec, taken_cnt} <= '0;
    else
    begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
      if (irq_ack && irq_req)
      begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
      else if (irq_req && ack_en && !irq_ack)
      begin
        wait_cnt <= wait_cnt + 4'h1;
        irq_ack <= (wait_cnt == ack_delay);
      end
    end
  end
endmodule : vic_core_model

// ===== verif/vic_ctrl_bench.sv
// Self-checking bench for vic_ctrl with a core model on the ack side.
// Assumes zero-wait APB and one-cycle event pulses on core_clk.
`timescale 1ns/1ps
module vic_ctrl_bench;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, taken_cnt, seen;
  logic [31:0] pwdata, prdata, rd;
  logic interval_timer_irq, serial_done_irq, event_counter_match_irq;
  logic pulse_gen_match_irq, key_scan_timing_irq, watch_timer_test_source;
  logic any_edge_ext_irq, ext_irq_a, ext_irq_b, rising_edge_test_input;
  logic irq_req, irq_ack, irq_return, standby_wake, ack_en;
  logic [15:0] irq_vector, taken_vec;
  logic [3:0] ack_delay;
  logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [15:0] order [8] = '{16'h0002, 16'h0002, 16'h0004, 16'h0006,
    16'h0008, 16'h000A, 16'h000C, 16'h000E};
  int n_errors;
  int checked;

  vic_ctrl dut (.core_clk, .arst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .interval_timer_irq,
    .serial_done_irq, .event_counter_match_irq, .pulse_gen_match_irq,
    .key_scan_timing_irq, .watch_timer_test_source, .any_edge_ext_irq,
    .ext_irq_a, .ext_irq_b, .rising_edge_test_input, .irq_req,
    .irq_vector, .irq_ack, .irq_return, .standby_wake);
  vic_core_model core (.core_clk, .arst_n, .irq_req, .irq_vector, .ack_en,
    .ack_delay, .irq_ack, .taken_vec, .taken_cnt);

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic bail();
    n_errors++;
    final_report();
  endtask : bail

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1)
      bail();
    @(posedge core_clk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask : rdc

  // Waits for the core model to take one more vector
  task automatic take(input logic [15:0] e);
    int k;
    k = 0;
    while (taken_cnt === seen && k < 60)
    begin
      @(posedge core_clk);
      k++;
    end
    if (taken_cnt === seen)
      bail();
    seen = taken_cnt;
    check({16'h0000, taken_vec}, {16'h0000, e});
  endtask : take

  task automatic ret();
    irq_return <= 1'b1;
    @(posedge core_clk);
    irq_return <= 1'b0;
    @(posedge core_clk);
  endtask : ret

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {interval_timer_irq, serial_done_irq, event_counter_match_irq,
      pulse_gen_match_irq, key_scan_timing_irq} = '0;
    {watch_timer_test_source, any_edge_ext_irq, ext_irq_a} = '0;
    {ext_irq_b, rising_edge_test_input, irq_return, ack_en} = '0;
    {ack_delay, seen} = '0;
    n_errors = 0;
    checked = 0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    // Reset values, then unmapped reads and writes
    foreach (offs[i]) rdc(offs[i], 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 8'h18, 32'h0000_FFFF);
    check({31'h0, err}, 32'h0000_0001);
    // All vectored flags at once, slow core; taken in fixed order
    ack_delay <= 4'h3;
    apb(1'b1, 8'h04, 32'h0000_03FF);
    apb(1'b1, 8'h00, 32'h0000_00FF);
    apb(1'b1, 8'h08, 32'h0000_0008);
    ack_en <= 1'b1;
    foreach (order[i])
    begin
      take(order[i]);
      ret();
    end
    rdc(8'h00, 32'h0000_0000);
    // Hardware events and rising pin edges, polled with master off
    ack_en <= 1'b0;
    apb(1'b1, 8'h08, 32'h0000_0000);
    {interval_timer_irq, serial_done_irq, event_counter_match_irq,
      pulse_gen_match_irq, key_scan_timing_irq} <= 5'h1F;
    {watch_timer_test_source, any_edge_ext_irq, ext_irq_a, ext_irq_b,
      rising_edge_test_input} <= 5'h1F;
    @(posedge core_clk);
    {interval_timer_irq, serial_done_irq, event_counter_match_irq,
      pulse_gen_match_irq, key_scan_timing_irq} <= 5'h00;
    watch_timer_test_source <= 1'b0;
    repeat (6) @(posedge core_clk);
    rdc(8'h00, 32'h0000_03FF);
    // Falling pins: only the any-edge input and falling-mode input count
    apb(1'b1, 8'h0C, 32'h0000_0001);
    repeat (6) @(posedge core_clk);
    apb(1'b1, 8'h00, 32'h0000_0000);
    {any_edge_ext_irq, ext_irq_a, ext_irq_b, rising_edge_test_input} <= 4'h0;
    repeat (6) @(posedge core_clk);
    rdc(8'h00, 32'h0000_0006);
    // Selects swapped: ext_b falling, ext_a back to rising, pins rise
    apb(1'b1, 8'h0C, 32'h0000_0002);
    apb(1'b1, 8'h00, 32'h0000_0000);
    {any_edge_ext_irq, ext_irq_a, ext_irq_b, rising_edge_test_input} <= 4'hF;
    repeat (6) @(posedge core_clk);
    rdc(8'h00, 32'h0000_0106);
    // Test sources wake the part but never vector
    apb(1'b1, 8'h04, 32'h0000_0300);
    apb(1'b1, 8'h08, 32'h0000_0008);
    apb(1'b1, 8'h00, 32'h0000_0300);
    repeat (4) @(posedge core_clk);
    check({30'h0, irq_req, standby_wake}, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0004);
    check({30'h0, irq_req, standby_wake}, 32'h0000_0000);
    // Master enable off holds the request back until set
    apb(1'b1, 8'h08, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0004);
    repeat (4) @(posedge core_clk);
    check({30'h0, irq_req, standby_wake}, 32'h0000_0001);
    ack_en <= 1'b1;
    ack_delay <= 4'h0;
    apb(1'b1, 8'h08, 32'h0000_0008);
    take(16'h0004);
    ret();
    // Selected source nests; an unselected one waits its turn
    apb(1'b1, 8'h04, 32'h0000_00FF);
    apb(1'b1, 8'h08, 32'h0000_000D);
    apb(1'b1, 8'h00, 32'h0000_0080);
    take(16'h000E);
    apb(1'b1, 8'h00, 32'h0000_0010);
    repeat (4) @(posedge core_clk);
    check({31'h0, irq_req}, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0030);
    take(16'h000A);
    rdc(8'h10, 32'h0000_0D00);
    ret();
    ret();
    take(16'h0008);
    ret();
    final_report();
  end
endmodule : vic_ctrl_bench

bind vic_ctrl vic_ctrl_monitor mon (.core_clk, .arst_n, .paddr, .psel,
  .penable, .pwrite, .pwdata, .pready, .pslverr, .interval_timer_irq,
  .irq_req, .irq_vector, .irq_ack, .standby_wake);
